// ===== verilog/nvc_top.sv
// Notes on behaviour
// - New fuse value acts only after reset.
// - Fuses read by plain load, no command.
// - Reset aborts a running write or erase.
// - EEPROM ready sets the ready flag.
// - Interrupt while enabled and flag set.
// - Idle controller sleeps with the system.
// - Busy write keeps clocks alive through sleep.
// - Ready interrupt wakes only from idle sleep.
// - Wake-up clears the page buffer.
// - Command changes only inside unlock window.
// - Codes 0-3: none, write, erase, erase-write.
// - Codes 4-6: clear, chip erase, EEPROM erase.
// - Fuse write starts only from debug port.
// - Boot lock zeroes boot reads and fetches.
// - Boot lock written from boot; reset clears.
// - Boot lock acts after leaving boot section.
// - Application protect blocks writes; reset clears.
// - Busy bits show EEPROM and flash activity.
// - Write fault shows last operation failed.
// - Ready flag cleared by writing one.
module nvc_top #(
  parameter int ADDR_W = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic unlock_valid,
  input wire logic dbg_port_access,
  input wire logic exec_in_boot,
  input wire logic pbuf_wr_valid,
  input wire logic [15:0] pbuf_wr_addr,
  input wire logic pbuf_mixed,
  output nvc_pkg::nvc_op_req_t op_req,
  output logic array_go,
  input wire logic array_done,
  output logic pbuf_clear,
  output logic cpu_halt,
  input wire logic [nvc_pkg::FUSE_AW-1:0] fuse_rd_addr,
  output logic [7:0] fuse_rd_data,
  output logic [7:0] fuse_boot_end,
  output logic [7:0] fuse_app_end,
  input wire logic mem_rd_boot,
  input wire logic [7:0] mem_rd_data,
  output logic [7:0] mem_rd_gated,
  input wire logic fetch_boot,
  input wire logic [15:0] fetch_data,
  output logic [15:0] fetch_gated,
  input wire nvc_pkg::nvc_sleep_t sleep_in,
  output logic clk_keep_req,
  output logic ctrl_asleep,
  output logic wake_req,
  output logic irq
);
  import nvc_pkg::*;

  // Register decoding from the word address.
  function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[5:2];
  endfunction

  // Whether a decoded index names a mapped register.
  function automatic logic is_mapped(input logic [3:0] i);
    is_mapped = (i == IDX_CMD_CTRL) || (i == IDX_LOCK_CTRL) || (i == IDX_STATUS) ||
                (i == IDX_INT_EN) || (i == IDX_INT_FLAG) || (i == IDX_FUSE_DATA) || (i == IDX_TARGET);
  endfunction

  logic wr_acc; // APB write access phase.
  logic [3:0] idx; // Decoded register index.
  logic [2:0] cmd_r; // Command field.
  logic app_protect_r; // Application code write protect.
  logic boot_lock_r; // Boot lock as written.
  logic boot_lock_eff_r; // Boot lock in force.
  logic boot_leave_pend_r; // Lock written, waiting to leave the boot section.
  logic fault_r; // Last operation failed.
  logic ee_busy_r; // EEPROM operation in progress.
  logic fl_busy_r; // Flash operation in progress.
  logic int_en_r; // Ready interrupt enable.
  logic ready_flag_r; // Ready interrupt flag.
  logic [15:0] fuse_val_r; // Fuse value to program.
  logic [15:0] target_r; // Target location.
  logic [7:0] fuse_mem [FUSE_NUM]; // Stored fuse bytes.
  logic [7:0] syscfg_act_r; // System fuse in force since reset.
  logic [7:0] boot_end_act_r; // Boot end fuse in force since reset.
  logic [7:0] app_end_act_r; // App end fuse in force since reset.
  logic captured_r; // Fuse copy taken after reset release.
  logic sleep_d_r; // Sleep request one cycle ago.
  logic seq_start; // Start the sequencer.
  logic seq_busy; // Sequencer has an operation.
  logic seq_done; // Operation completed this cycle.
  logic start_ok; // Command may start.
  logic start_bad; // Command refused as an error.
  logic target_ee; // Target lies in EEPROM.
  logic [7:0] target_page; // Flash page of the target.
  logic target_boot; // Target in boot section.
  logic target_app; // Target in application code section.
  logic wr_cmd; // Command register write taken.
  nvc_cmd_t new_cmd; // Command being written.
  nvc_op_req_t req_r; // Latched operation request.

  assign wr_acc = psel && penable && pwrite;
  assign idx = reg_index(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !is_mapped(idx);

  // The unlock window is judged by the core and sampled here at the write.
  assign wr_cmd = wr_acc && (idx == IDX_CMD_CTRL) && unlock_valid;
  assign new_cmd = nvc_cmd_t'(pwdata[CMD_W-1:0]);

  // Where the target lies, from the fuse values in force.
  assign target_ee = (target_r >= EE_BASE) && (target_r <= EE_LAST);
  assign target_page = 8'((target_r - FLASH_BASE) >> 8);
  assign target_boot = !target_ee && (target_page < boot_end_act_r);
  assign target_app = !target_ee && !target_boot &&
                      ((app_end_act_r == 8'h00) || (target_page < app_end_act_r));

  // Decide whether a command may start and whether it is a write fault.
  always_comb begin
    start_ok = 1'b0;
    start_bad = 1'b0;
    if (wr_cmd && new_cmd != CMD_NONE) begin
      unique case (new_cmd)
        CMD_PAGE_WRITE, CMD_PAGE_ERASE, CMD_ERASE_WRITE: begin
          // Boot is never writable by the core; app code is once protected.
          start_bad = seq_busy || pbuf_mixed || target_boot || (target_app && app_protect_r);
          start_ok = !start_bad;
        end
        CMD_BUF_CLEAR, CMD_FULL_ERASE, CMD_EE_ERASE: begin
          start_bad = seq_busy;
          start_ok = !start_bad;
        end
        CMD_FUSE_PROG: begin
          start_bad = seq_busy || !dbg_port_access;
          start_ok = !start_bad;
        end
        default: begin
          start_ok = 1'b0;
        end
      endcase
    end
  end

  assign seq_start = start_ok;

  // Sequencer for the running operation.
  nvc_op_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .start(seq_start),
    .local_timed(new_cmd == CMD_BUF_CLEAR),
    .array_done(array_done),
    .busy(seq_busy),
    .go(array_go),
    .done(seq_done)
  );

  // Command field; unprotected writes leave it unchanged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= RST_BYTE[CMD_W-1:0];
    end else if (wr_cmd) begin
      cmd_r <= new_cmd;
    end
  end

  // Latch the request handed to the array when a command starts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_r <= '0;
    end else if (seq_start) begin
      req_r.cmd <= new_cmd;
      req_r.target <= target_r;
      req_r.to_eeprom <= target_ee || (new_cmd == CMD_EE_ERASE) || (new_cmd == CMD_FUSE_PROG);
      req_r.keep_eeprom <= syscfg_act_r[FUSE_KEEP_EE_BIT];
    end
  end

  assign op_req = req_r;

  // Busy flags per array, dropped by reset so the operation aborts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ee_busy_r <= 1'b0;
      fl_busy_r <= 1'b0;
    end else if (seq_start) begin
      unique case (new_cmd)
        CMD_PAGE_WRITE, CMD_PAGE_ERASE, CMD_ERASE_WRITE: begin
          ee_busy_r <= target_ee;
          fl_busy_r <= !target_ee;
        end
        CMD_FULL_ERASE: begin
          ee_busy_r <= !syscfg_act_r[FUSE_KEEP_EE_BIT];
          fl_busy_r <= 1'b1;
        end
        CMD_EE_ERASE, CMD_FUSE_PROG: begin
          ee_busy_r <= 1'b1;
          fl_busy_r <= 1'b0;
        end
        default: begin
          ee_busy_r <= 1'b0;
          fl_busy_r <= 1'b1;
        end
      endcase
    end else if (seq_done) begin
      ee_busy_r <= 1'b0;
      fl_busy_r <= 1'b0;
    end
  end

  // The core stalls while flash is busy, which covers the buffer clear, and during an EEPROM erase.
  assign cpu_halt = fl_busy_r || (ee_busy_r && req_r.cmd == CMD_EE_ERASE);

  // Write fault holds the outcome of the most recent command.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r <= 1'b0;
    end else if (start_ok || start_bad) begin
      fault_r <= start_bad;
    end
  end

  // Section lock bits: set only, cleared only by reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      app_protect_r <= 1'b0;
      boot_lock_r <= 1'b0;
    end else if (wr_acc && idx == IDX_LOCK_CTRL) begin
      if (pwdata[LOCK_APP_BIT]) begin
        app_protect_r <= 1'b1;
      end
      if (pwdata[LOCK_BOOT_BIT] && exec_in_boot) begin
        boot_lock_r <= 1'b1;
      end
    end
  end

  // Boot lock takes force once execution first leaves the boot section.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_lock_eff_r <= 1'b0;
      boot_leave_pend_r <= 1'b0;
    end else if (boot_lock_r && !boot_lock_eff_r) begin
      if (exec_in_boot) begin
        boot_leave_pend_r <= 1'b1;
      end else if (boot_leave_pend_r) begin
        boot_lock_eff_r <= 1'b1;
      end
    end
  end

  // Boot reads and fetches return zero while locked.
  assign mem_rd_gated = (boot_lock_eff_r && mem_rd_boot) ? RST_BYTE : mem_rd_data;
  assign fetch_gated = (boot_lock_eff_r && fetch_boot) ? RST_WORD : fetch_data;

  // Interrupt enable register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en_r <= 1'b0;
    end else if (wr_acc && idx == IDX_INT_EN) begin
      int_en_r <= pwdata[INT_READY_BIT];
    end
  end

  // Ready flag: set when an EEPROM operation ends; set wins over clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_flag_r <= 1'b0;
    end else if (seq_done && ee_busy_r) begin
      ready_flag_r <= 1'b1;
    end else if (wr_acc && idx == IDX_INT_FLAG && pwdata[INT_READY_BIT]) begin
      ready_flag_r <= 1'b0;
    end
  end

  // Level request while enabled and flagged.
  assign irq = int_en_r && ready_flag_r;

  // Fuse value and target registers; page buffer stores track the target.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_val_r <= RST_WORD;
      target_r <= RST_WORD;
    end else begin
      if (wr_acc && idx == IDX_FUSE_DATA) begin
        fuse_val_r <= pwdata[15:0];
      end
      if (pbuf_wr_valid) begin
        target_r <= pbuf_wr_addr;
      end else if (wr_acc && idx == IDX_TARGET) begin
        target_r <= pwdata[15:0];
      end
    end
  end

  // Fuse store survives reset; written at the end of a fuse command.
  always_ff @(posedge pclk) begin
    if (seq_done && req_r.cmd == CMD_FUSE_PROG) begin
      fuse_mem[req_r.target[FUSE_AW-1:0]] <= fuse_val_r[7:0];
    end
  end

  // Fuse copy in force is captured once after each reset release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      captured_r <= 1'b0;
      syscfg_act_r <= RST_BYTE;
      boot_end_act_r <= RST_BYTE;
      app_end_act_r <= RST_BYTE;
    end else if (!captured_r) begin
      captured_r <= 1'b1;
      syscfg_act_r <= fuse_mem[FUSE_SYSCFG_IDX];
      boot_end_act_r <= fuse_mem[FUSE_BOOTEND_IDX];
      app_end_act_r <= fuse_mem[FUSE_APPEND_IDX];
    end
  end

  assign fuse_boot_end = boot_end_act_r;
  assign fuse_app_end = app_end_act_r;

  // Plain load path to the stored fuses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_rd_data <= RST_BYTE;
    end else begin
      fuse_rd_data <= fuse_mem[fuse_rd_addr];
    end
  end

  // Sleep handling: clocks stay on while an operation runs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_d_r <= 1'b0;
    end else begin
      sleep_d_r <= sleep_in.sleep_req;
    end
  end

  assign clk_keep_req = sleep_in.sleep_req && seq_busy;
  assign ctrl_asleep = sleep_in.sleep_req && !seq_busy;
  assign wake_req = sleep_in.sleep_req && irq && (sleep_in.mode == SLEEP_IDLE);

  // Page buffer is erased after wake-up and after every finished command.
  assign pbuf_clear = (sleep_d_r && !sleep_in.sleep_req) || seq_done;

  // Read data mux, registered so it is stable in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (idx)
        IDX_CMD_CTRL: prdata <= {29'h0000_0000, cmd_r};
        IDX_LOCK_CTRL: prdata <= {30'h0000_0000, boot_lock_r, app_protect_r};
        IDX_STATUS: prdata <= {29'h0000_0000, fault_r, ee_busy_r, fl_busy_r};
        IDX_INT_EN: prdata <= {31'h0000_0000, int_en_r};
        IDX_INT_FLAG: prdata <= {31'h0000_0000, ready_flag_r};
        IDX_FUSE_DATA: prdata <= {16'h0000, fuse_val_r};
        IDX_TARGET: prdata <= {16'h0000, target_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ===== verilog/nvc_pkg.sv
package nvc_pkg;

  // Register indices; the APB byte address is four times the index.
  localparam logic [3:0] IDX_CMD_CTRL = 4'h0;
  localparam logic [3:0] IDX_LOCK_CTRL = 4'h1;
  localparam logic [3:0] IDX_STATUS = 4'h2;
  localparam logic [3:0] IDX_INT_EN = 4'h3;
  localparam logic [3:0] IDX_INT_FLAG = 4'h4;
  localparam logic [3:0] IDX_FUSE_DATA = 4'h6;
  localparam logic [3:0] IDX_TARGET = 4'h8;

  // Field positions.
  localparam int CMD_W = 3;
  localparam int LOCK_APP_BIT = 0;
  localparam int LOCK_BOOT_BIT = 1;
  localparam int ST_FLASH_BUSY_FLAG_BIT = 0;
  localparam int ST_EEPROM_BUSY_FLAG_BIT = 1;
  localparam int ST_FAULT_BIT = 2;
  localparam int INT_READY_BIT = 0;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Memory map of the arrays the commands target.
  localparam logic [15:0] EE_BASE = 16'h1400;
  localparam logic [15:0] EE_LAST = 16'h14FF;
  localparam logic [15:0] FLASH_BASE = 16'h8000;

  // Fuse bytes this block consumes, and the fuse store size.
  localparam int FUSE_NUM = 16;
  localparam int FUSE_AW = 4;
  localparam logic [3:0] FUSE_SYSCFG_IDX = 4'h5;
  localparam logic [3:0] FUSE_APPEND_IDX = 4'h7;
  localparam logic [3:0] FUSE_BOOTEND_IDX = 4'h8;
  localparam int FUSE_KEEP_EE_BIT = 0;

  // Page buffer clear runs for seven cycles and holds the core for eight.
  localparam logic [3:0] PBC_CYCLES = 4'h7;

  // Sleep mode encodings.
  localparam logic [1:0] SLEEP_IDLE = 2'h0;

  // Command codes.
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_PAGE_WRITE = 3'h1,
    CMD_PAGE_ERASE = 3'h2,
    CMD_ERASE_WRITE = 3'h3,
    CMD_BUF_CLEAR = 3'h4,
    CMD_FULL_ERASE = 3'h5,
    CMD_EE_ERASE = 3'h6,
    CMD_FUSE_PROG = 3'h7
  } nvc_cmd_t;

  // Request issued to the array.
  typedef struct packed {
    nvc_cmd_t cmd;
    logic [15:0] target;
    logic to_eeprom;
    logic keep_eeprom;
  } nvc_op_req_t;

  // Sleep controls from the power manager.
  typedef struct packed {
    logic sleep_req;
    logic [1:0] mode;
  } nvc_sleep_t;

endpackage

// ===== verilog/nvc_op_seq.sv
// Tracks one running operation from start to completion.
module nvc_op_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic local_timed,
  input wire logic array_done,
  output logic busy,
  output logic go,
  output logic done
);
  import nvc_pkg::*;

  // One-hot sequencer states.
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b001,
    SQ_RUN = 3'b010,
    SQ_FIN = 3'b100
  } nvc_seq_t;

  nvc_seq_t state_r; // Current state.
  logic timed_r; // Running operation finishes by the local counter.
  logic [3:0] cnt_r; // Cycles left for a locally timed operation.

  // State register; reset drops any running operation at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SQ_IDLE;
    end else begin
      unique case (state_r)
        SQ_IDLE: begin
          if (start) begin
            state_r <= SQ_RUN;
          end
        end
        SQ_RUN: begin
          if (timed_r ? (cnt_r == 4'h1) : array_done) begin
            state_r <= SQ_FIN;
          end
        end
        SQ_FIN: begin
          state_r <= SQ_IDLE;
        end
        default: begin
          state_r <= SQ_IDLE;
        end
      endcase
    end
  end

  // Local cycle counter, loaded when a timed operation starts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timed_r <= 1'b0;
      cnt_r <= 4'h0;
    end else if (state_r == SQ_IDLE && start) begin
      timed_r <= local_timed;
      cnt_r <= PBC_CYCLES;
    end else if (state_r == SQ_RUN && cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  // Busy covers start through finish; go asks the array to run.
  assign busy = (state_r != SQ_IDLE);
  assign go = (state_r == SQ_RUN) && !timed_r;
  assign done = (state_r == SQ_FIN);
endmodule

// ===== sim/nvc_array_model.sv
// Stand-in for the memory array: it finishes a running operation after a set delay.
module nvc_array_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic array_go,
  input wire logic [7:0] delay,
  output logic array_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r; // Cycles spent on the current operation.
  // Count while an operation runs, then pulse done once; reset drops everything.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      array_done <= 1'b0;
    end else if (array_go && !array_done && cnt_r >= delay) begin
      cnt_r <= 8'h00;
      array_done <= 1'b1;
    end else begin
      cnt_r <= (array_go && !array_done) ? cnt_r + 8'h01 : 8'h00;
      array_done <= 1'b0;
    end
  end
endmodule

// ===== sim/nvc_top_props.sv
// Watches command start, locks, interrupt and sleep behaviour at the top ports.
module nvc_top_props #(
  parameter int ADDR_W = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic unlock_valid,
  input wire logic dbg_port_access,
  input wire logic exec_in_boot,
  input wire nvc_pkg::nvc_op_req_t op_req,
  input wire logic array_go,
  input wire logic array_done,
  input wire logic cpu_halt,
  input wire logic mem_rd_boot,
  input wire logic [7:0] mem_rd_data,
  input wire logic [7:0] mem_rd_gated,
  input wire logic fetch_boot,
  input wire logic [15:0] fetch_gated,
  input wire nvc_pkg::nvc_sleep_t sleep_in,
  input wire logic clk_keep_req,
  input wire logic ctrl_asleep,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import nvc_pkg::*;
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic cmd_wr; // Command write in its access phase.
  logic flag_wr; // Interrupt flag write of a one.
  logic [2:0] cmd_code; // Code carried by the write data.
  logic lock_armed_r; // Boot lock written from the boot section.
  logic lock_pend_r; // Execution has left the boot section since.
  logic lock_on_r; // Boot lock surely in force, one cycle late for margin.
  assign cmd_wr = psel && penable && pwrite && paddr[5:2] == IDX_CMD_CTRL;
  assign flag_wr = psel && penable && pwrite && paddr[5:2] == IDX_INT_FLAG && pwdata[0];
  assign cmd_code = pwdata[2:0];
  // Follow the boot lock from its write to the moment it must bite.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_armed_r <= 1'b0;
      lock_pend_r <= 1'b0;
      lock_on_r <= 1'b0;
    end else begin
      if (psel && penable && pwrite && paddr[5:2] == IDX_LOCK_CTRL && pwdata[LOCK_BOOT_BIT] && exec_in_boot) begin
        lock_armed_r <= 1'b1;
      end
      if (lock_armed_r && !exec_in_boot) begin
        lock_pend_r <= 1'b1;
      end
      if (lock_pend_r) begin
        lock_on_r <= 1'b1;
      end
    end
  end
  a_cmd_needs_key: assert property (cmd_wr && !unlock_valid |=> !$rose(array_go))
    else $error("command started outside the unlock window");
  a_fuse_debug_only: assert property (cmd_wr && cmd_code == CMD_FUSE_PROG && !dbg_port_access |=> !$rose(array_go))
    else $error("fuse write started from the core");
  a_start_code: assert property ($rose(array_go) |-> $past(cmd_wr) && op_req.cmd == $past(cmd_code))
    else $error("array request code differs from the written code");
  a_go_ends: assert property (array_go && array_done |=> !array_go)
    else $error("array request outlived its completion");
  a_clear_halts: assert property (cmd_wr && unlock_valid && cmd_code == CMD_BUF_CLEAR && !cpu_halt
    && !array_go |=> (cpu_halt && !array_go) [*7])
    else $error("buffer clear did not hold the core");
  a_boot_zeroed: assert property (lock_on_r |-> (!mem_rd_boot || mem_rd_gated == 8'h00)
    && (!fetch_boot || fetch_gated == 16'h0000))
    else $error("boot section visible while locked");
  a_lock_late: assert property (lock_armed_r && !lock_pend_r && exec_in_boot |-> mem_rd_gated == mem_rd_data)
    else $error("boot lock bit before leaving the boot section");
  a_irq_clear: assert property (flag_wr && !$past(array_done) |=> !irq)
    else $error("interrupt stayed after flag clear");
  a_sleep_keeps: assert property (array_go && sleep_in.sleep_req |-> clk_keep_req && !ctrl_asleep)
    else $error("clock released during a running write");
  c_started: cover property ($rose(array_go));
  c_locked_read: cover property (lock_on_r && mem_rd_boot);
  c_sleep_busy: cover property (array_go && sleep_in.sleep_req);
endmodule
bind nvc_top nvc_top_props #(.ADDR_W(ADDR_W)) u_props (.*);

// ===== sim/nvm_command_controller_test.sv
// Drives the block over APB and checks command, lock, interrupt and sleep behaviour.
module nvm_command_controller_test;
  timeunit 1ns;
  timeprecision 1ps;
  import nvc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_val;
  logic [5:0] paddr;
  logic [31:0] pwdata, prdata, rd_val;
  logic unlock_valid, dbg_port_access, exec_in_boot, pbuf_wr_valid, pbuf_mixed;
  logic [15:0] pbuf_wr_addr, fetch_data, fetch_gated;
  logic array_go, array_done, pbuf_clear, cpu_halt, mem_rd_boot, fetch_boot;
  logic [3:0] fuse_rd_addr;
  logic [7:0] fuse_rd_data, fuse_boot_end, fuse_app_end, mem_rd_data, mem_rd_gated, delay;
  logic clk_keep_req, ctrl_asleep, wake_req, irq;
  nvc_op_req_t op_req;
  nvc_sleep_t sleep_in;
  int bad_count = 0;
  int n_tests = 0;
  logic [3:0] f_idx [3] = '{4'h5, 4'h7, 4'h8}; // Fuses set up: keep EEPROM, app end, boot end.
  logic [7:0] f_val [3] = '{8'h01, 8'h00, 8'h04};
  nvc_top uut (.*);
  nvc_array_model u_arr (.pclk, .presetn, .array_go, .delay, .array_done);
  // Free-running clock.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("%0d comparisons, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer plus an idle cycle; read data and error are kept.
  task automatic apb(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_val = prdata;
    err_val = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      tally_and_finish();
    end
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [3:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd_val, exp);
  endtask
  // Polls the busy bits under a bound.
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, IDX_STATUS, 32'h0);
      n++;
    end while (rd_val[1:0] !== 2'b00 && n < 100);
    if (n >= 100) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  // Issues a command in the unlock window and checks the fault bit left behind.
  task automatic cmd(input logic [2:0] code, input logic dbg, input logic fault);
    unlock_valid <= 1'b1;
    dbg_port_access <= dbg;
    apb(1'b1, IDX_CMD_CTRL, {29'h0, code});
    unlock_valid <= 1'b0;
    dbg_port_access <= 1'b0;
    wait_idle();
    chk(rd_val, {29'h0, fault, 2'b00});
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
  // Main sequence.
  initial begin
    int n;
    {psel, penable, pwrite, unlock_valid, dbg_port_access, exec_in_boot} = '0;
    {pbuf_wr_valid, pbuf_mixed, mem_rd_boot, fetch_boot, fuse_rd_addr} = '0;
    {paddr, pwdata, pbuf_wr_addr} = '0;
    mem_rd_data = 8'h5A;
    fetch_data = 16'hA55A;
    sleep_in = '0;
    delay = 8'h02;
    presetn = 1'b0;
    do_reset();
    for (int i = 0; i < 9; i++) begin
      if (i != 5 && i != 7) begin
        rdchk(4'(i), 32'h0);
      end
    end
    rdchk(4'h5, 32'h0);
    chk(err_val, 1'b1);
    $display("test reset values done");
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, IDX_TARGET, {28'h0, f_idx[i]});
      apb(1'b1, IDX_FUSE_DATA, {24'h0, f_val[i]});
      cmd(CMD_FUSE_PROG, 1'b1, 1'b0);
      fuse_rd_addr <= f_idx[i];
      repeat (2) @(posedge pclk);
      chk(fuse_rd_data, f_val[i]);
    end
    cmd(CMD_FUSE_PROG, 1'b0, 1'b1);
    do_reset();
    chk({fuse_boot_end, fuse_app_end}, 16'h0400);
    apb(1'b1, IDX_FUSE_DATA, 32'h2);
    cmd(CMD_FUSE_PROG, 1'b1, 1'b0);
    chk(fuse_boot_end, 8'h04);
    $display("test fuses done");
    pbuf_wr_addr <= EE_BASE;
    pbuf_wr_valid <= 1'b1;
    @(posedge pclk);
    pbuf_wr_valid <= 1'b0;
    rdchk(IDX_TARGET, {16'h0, EE_BASE});
    apb(1'b1, IDX_CMD_CTRL, 32'h1);
    rdchk(IDX_STATUS, 32'h0);
    for (int i = 1; i < 7; i++) begin
      delay <= 8'(i * 3);
      cmd(3'(i), 1'b0, 1'b0);
      chk(op_req.cmd, i);
      if (i < 4) begin
        chk(op_req.to_eeprom, 1'b1);
      end
    end
    chk(op_req.cmd == CMD_EE_ERASE, 1'b1);
    cmd(CMD_FULL_ERASE, 1'b0, 1'b0);
    chk(op_req.keep_eeprom, 1'b1);
    $display("test command codes done");
    apb(1'b1, IDX_TARGET, {16'h0, FLASH_BASE});
    cmd(CMD_PAGE_WRITE, 1'b0, 1'b1);
    apb(1'b1, IDX_TARGET, {16'h0, EE_BASE});
    pbuf_mixed <= 1'b1;
    cmd(CMD_PAGE_WRITE, 1'b0, 1'b1);
    pbuf_mixed <= 1'b0;
    cmd(CMD_PAGE_WRITE, 1'b0, 1'b0);
    apb(1'b1, IDX_TARGET, 32'h8400);
    cmd(CMD_PAGE_ERASE, 1'b0, 1'b0);
    apb(1'b1, IDX_LOCK_CTRL, 32'h1);
    apb(1'b1, IDX_LOCK_CTRL, 32'h0);
    rdchk(IDX_LOCK_CTRL, 32'h1);
    cmd(CMD_PAGE_ERASE, 1'b0, 1'b1);
    $display("test refusals done");
    apb(1'b1, IDX_LOCK_CTRL, 32'h2);
    rdchk(IDX_LOCK_CTRL, 32'h1);
    exec_in_boot <= 1'b1;
    {mem_rd_boot, fetch_boot} <= 2'b11;
    apb(1'b1, IDX_LOCK_CTRL, 32'h2);
    rdchk(IDX_LOCK_CTRL, 32'h3);
    chk(mem_rd_gated, 8'h5A);
    exec_in_boot <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({fetch_gated, mem_rd_gated}, 24'h0);
    $display("test boot lock done");
    apb(1'b1, IDX_TARGET, {16'h0, EE_BASE});
    delay <= 8'h28;
    unlock_valid <= 1'b1;
    apb(1'b1, IDX_CMD_CTRL, 32'h1);
    unlock_valid <= 1'b0;
    sleep_in <= {1'b1, 2'h2};
    repeat (4) @(posedge pclk);
    chk({clk_keep_req, ctrl_asleep}, 2'b10);
    wait_idle();
    chk(ctrl_asleep, 1'b1);
    sleep_in <= '0;
    n = 0;
    while (pbuf_clear !== 1'b1 && n < 4) begin
      @(posedge pclk);
      n++;
    end
    chk(pbuf_clear, 1'b1);
    $display("test sleep done");
    apb(1'b1, IDX_INT_FLAG, 32'h1);
    apb(1'b1, IDX_INT_EN, 32'h1);
    chk(irq, 1'b0);
    cmd(CMD_PAGE_WRITE, 1'b0, 1'b0);
    chk(irq, 1'b1);
    rdchk(IDX_INT_FLAG, 32'h1);
    apb(1'b1, IDX_INT_FLAG, 32'h0);
    chk(irq, 1'b1);
    sleep_in <= {1'b1, 2'h2};
    repeat (2) @(posedge pclk);
    chk(wake_req, 1'b0);
    sleep_in <= {1'b1, SLEEP_IDLE};
    repeat (2) @(posedge pclk);
    chk(wake_req, 1'b1);
    sleep_in <= '0;
    apb(1'b1, IDX_INT_FLAG, 32'h1);
    chk(irq, 1'b0);
    rdchk(IDX_INT_FLAG, 32'h0);
    apb(1'b1, IDX_INT_EN, 32'h0);
    cmd(CMD_PAGE_WRITE, 1'b0, 1'b0);
    rdchk(IDX_INT_FLAG, 32'h1);
    chk(irq, 1'b0);
    $display("test interrupt done");
    unlock_valid <= 1'b1;
    apb(1'b1, IDX_CMD_CTRL, 32'h1);
    unlock_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(array_go, 1'b1);
    presetn <= 1'b0;
    @(posedge pclk);
    chk(array_go, 1'b0);
    do_reset();
    rdchk(IDX_STATUS, 32'h0);
    rdchk(IDX_LOCK_CTRL, 32'h0);
    $display("test abort done");
    tally_and_finish();
  end
endmodule
